// ===== addr_match.sv
// address comparator: 7-bit, 10-bit high and 10-bit low byte
`include "i2c_slave_defines.svh"
module addr_match (
   // received byte and phase
   input  wire logic [7:0] rx_byte,
   input  wire logic       tenbit,
   input  wire logic       low_byte,
   // own address and mask
   input  wire logic [7:0] own_address,
   input  wire logic [7:0] address_mask,
   // result
   output logic            hit
);
   logic [7:0] care;

   always_comb begin
      care = address_mask;
      if (!low_byte) begin
         care[0] = 1'b0;
      end
      if (tenbit && !low_byte) begin
         // high byte carries the r/w bit in bit 0
         hit = (rx_byte[7:3] == `TENBIT_HI_TAG) &&
               (rx_byte[2:1] == own_address[2:1]);
      end else begin
         // zero mask bit is don't-care
         hit = ((rx_byte ^ own_address) & care) == `BYTE_ZERO;
      end
   end
endmodule : addr_match

// ===== i2c_master_model.sv
// behavioural bus master on the two open-drain lines
module i2c_master_model (
   // clock and wired bus levels
   input  wire logic mclk,
   input  wire logic scl,
   input  wire logic sda,
   // released when high
   output logic      m_scl = 1'b1,
   output logic      m_sda = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic wt(input int n);
      repeat (n) @(negedge mclk);
   endtask : wt
   // bounded wait while the slave stretches
   task automatic rise;
      m_scl = 1'b1;
      for (int i = 0; i < 4000 && scl !== 1'b1; i++) @(negedge mclk);
   endtask : rise
   task automatic bitx(input logic b, output logic s);
      m_sda = b;
      wt(8);
      rise();
      wt(12);
      s = sda;
      m_scl = 1'b0;
      wt(6);
   endtask : bitx
   // doubles as restart mid-frame
   task automatic start;
      m_sda = 1'b1;
      wt(8);
      rise();
      wt(12);
      m_sda = 1'b0;
      wt(12);
      m_scl = 1'b0;
      wt(6);
   endtask : start
   task automatic stop;
      m_sda = 1'b0;
      wt(8);
      rise();
      wt(12);
      m_sda = 1'b1;
      wt(12);
   endtask : stop
   task automatic wbyte(input logic [7:0] b, output logic a);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(b[i], s);
      bitx(1'b1, a);
   endtask : wbyte
   task automatic rbyte(output logic [7:0] d, input logic a);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(a, s);
   endtask : rbyte
endmodule : i2c_master_model

// ===== i2c_slave.sv
// two-wire slave: conditions, acknowledge slot and address matching
//
// Contract
// - SDA falling while SCL high is Start.
// - Start seen while we pull SDA: collision.
// - SDA rising while SCL high is Stop.
// - Stop only after an SCL low period.
// - Restart accepted like Start, resets slave.
// - 10-bit prior-match flag kept until cleared.
// - start/stop enables add condition interrupts.
// - ninth pulse is acknowledge, transmitter releases.
// - ninth-pulse SDA level stored as ack status; code stores it only in st_tx.
// - hold enables: software ack value used.
// - no hold enables: hardware acknowledges.
// - full buffer or overflow withholds acknowledge.
// - ack time flag after eighth fall, holds.
// - four slave modes, 7/10-bit, with interrupts.
// - interrupt modes flag Start, Restart, Stop.
// - matched address copied to buffer, interrupt.
// - mismatch returns idle, nothing flagged.
// - address mask applies to matching.
// - 7-bit mode ignores address bit zero.
// - SDA low when expecting high: collision.
// - read streams bytes until nack, Restart or Stop.
// - 10-bit high byte is 11110 A9 A8.
`include "i2c_slave_defines.svh"
module i2c_slave
   import i2c_slave_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       reset,
   // bus pins
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_n,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   // configuration
   input  wire logic [3:0] port_mode_field,
   input  wire logic [7:0] own_address,
   input  wire logic [7:0] address_mask,
   input  wire logic       address_hold_enable,
   input  wire logic       data_hold_enable,
   input  wire logic       ack_data_value,
   input  wire logic       start_int_enable,
   input  wire logic       stop_int_enable,
   // software strobes
   input  wire logic       buffer_read,
   input  wire logic       int_clear,
   input  wire logic       overflow_clear,
   input  wire logic       collision_clear,
   input  wire logic       release_clock,
   input  wire logic       tx_load,
   input  wire logic [7:0] tx_data,
   // status
   output logic [7:0]      data_buffer,
   output logic            buffer_full_flag,
   output logic            receive_overflow_flag,
   output logic            serial_int_flag,
   output logic            ack_status_bit,
   output logic            ack_time_flag,
   output logic            start_seen,
   output logic            stop_seen,
   output logic            bus_collision,
   output logic            read_mode,
   output logic            prior_match,
   output logic            bus_active
);
   core_t r;
   core_t n;
   logic  scl;
   logic  sda;
   logic  hit;
   logic  scl_rise;
   logic  scl_fall;
   logic  start_cond;
   logic  stop_cond;
   logic  tenbit;
   logic  sp_mode;
   logic  slave_on;
   logic  full;
   logic  hold_en;

   line_sync u_scl_sync (
      .mclk       (mclk),
      .reset      (reset),
      .line_in    (scl_in),
      .line_level (scl)
   );

   line_sync u_sda_sync (
      .mclk       (mclk),
      .reset      (reset),
      .line_in    (sda_in),
      .line_level (sda)
   );

   addr_match u_match (
      .rx_byte      (r.shreg),
      .tenbit       (tenbit),
      .low_byte     (r.st == st_addr_lo),
      .own_address  (own_address),
      .address_mask (address_mask),
      .hit          (hit)
   );

   // mode decode
   assign tenbit   = (port_mode_field == `MODE_10BIT) ||
                     (port_mode_field == `MODE_10BIT_SP);
   assign sp_mode  = (port_mode_field == `MODE_7BIT_SP) ||
                     (port_mode_field == `MODE_10BIT_SP);
   assign slave_on = tenbit || sp_mode ||
                     (port_mode_field == `MODE_7BIT);

   // edges on the synchronised levels
   assign scl_rise   = scl && !r.scl_q;
   assign scl_fall   = !scl && r.scl_q;
   assign start_cond = scl && r.scl_q && !sda && r.sda_q;
   assign stop_cond  = scl && r.scl_q && sda && !r.sda_q;
   assign full       = r.bf || r.ov;
   assign hold_en    = (r.st == st_rx) ? data_hold_enable
                                       : address_hold_enable;

   always_comb begin
      n       = r;
      n.scl_q = scl;
      n.sda_q = sda;

      // software clears first so a hardware set in the same cycle wins
      if (buffer_read) begin
         n.bf = 1'b0;
      end
      if (int_clear) begin
         n.int_flag = 1'b0;
      end
      if (overflow_clear) begin
         n.ov = 1'b0;
      end
      if (collision_clear) begin
         n.collision = 1'b0;
      end
      if (tx_load) begin
         n.tx_buf   = tx_data;
         n.tx_ready = 1'b1;
      end
      // a read keeps the clock held until its byte is loaded
      if (release_clock && !(r.st == st_tx && r.tx_need)) begin
         n.scl_hold = 1'b0;
         if (r.ack_time) begin
            // late software decision takes over the slot
            n.ack_ok    = r.ack_hw && !ack_data_value;
            n.sda_drive = r.ack_hw && !ack_data_value;
         end
      end
      // next transmit byte arrives while the clock is held
      if (r.tx_need && r.tx_ready && r.st == st_tx) begin
         n.shreg     = r.tx_buf;
         n.sda_drive = !r.tx_buf[7];
         n.tx_ready  = 1'b0;
         n.tx_need   = 1'b0;
      end
      // release a cycle after sda settles, never together with it
      if (r.st == st_tx && r.scl_hold && !r.tx_need) begin
         n.scl_hold = 1'b0;
      end

      if (!slave_on) begin
         n.st        = st_idle;
         n.sda_drive = 1'b0;
         n.scl_hold  = 1'b0;
         n.ack_time  = 1'b0;
      end else if (start_cond) begin
         // start and restart both reset the byte logic
         if (r.sda_drive) begin
            n.collision = 1'b1;
         end
         n.st         = st_addr_hi;
         n.bits       = `BITS_ZERO;
         n.low_seen   = 1'b0;
         n.bus_active = 1'b1;
         n.start_seen = 1'b1;
         n.stop_seen  = 1'b0;
         n.sda_drive  = 1'b0;
         n.scl_hold   = 1'b0;
         n.ack_time   = 1'b0;
         n.tx_need    = 1'b0;
         if (sp_mode || start_int_enable) begin
            n.int_flag = 1'b1;
         end
      end else if (stop_cond && r.low_seen) begin
         n.st          = st_idle;
         n.bus_active  = 1'b0;
         n.stop_seen   = 1'b1;
         n.start_seen  = 1'b0;
         n.prior_match = 1'b0;
         n.sda_drive   = 1'b0;
         n.scl_hold    = 1'b0;
         n.ack_time    = 1'b0;
         n.tx_need     = 1'b0;
         if (sp_mode || stop_int_enable) begin
            n.int_flag = 1'b1;
         end
      end else begin
         if (scl_fall) begin
            n.low_seen = 1'b1;
         end

         // rising edge: sample data or the master's acknowledge
         if (scl_rise && r.st != st_idle) begin
            n.bits = r.bits + 4'h1;
            if (r.bits < `BITS_DATA) begin
               n.shreg = {r.shreg[6:0], sda};
               if (r.st == st_tx && !r.sda_drive && !sda) begin
                  // lost the line while sending a one
                  n.collision = 1'b1;
                  n.st        = st_idle;
               end
            end else if (r.st == st_tx) begin
               n.ack_status = sda;
               if (sda) begin
                  // nack ends the read, wait for next start
                  n.st        = st_idle;
                  n.sda_drive = 1'b0;
               end
            end
         end

         // falling edge: shift out, open or close the ack slot
         if (scl_fall && r.st != st_idle) begin
            if (r.st == st_tx && r.bits != `BITS_ZERO &&
                r.bits < `BITS_DATA) begin
               n.sda_drive = !r.shreg[7];
            end else if (r.bits == `BITS_DATA) begin
               if (r.st == st_tx) begin
                  n.sda_drive = 1'b0;
               end else begin
                  n.st_next = st_idle;
                  if (r.st == st_rx) begin
                     n.st_next = st_rx;
                  end else if (r.st == st_addr_lo) begin
                     if (hit) begin
                        n.st_next     = st_rx;
                        n.prior_match = 1'b1;
                     end
                  end else if (tenbit) begin
                     if (!hit || !r.shreg[0]) begin
                        n.prior_match = 1'b0;
                     end
                     if (hit && !r.shreg[0]) begin
                        n.st_next = st_addr_lo;
                     end else if (hit && r.prior_match) begin
                        n.st_next = st_tx;
                     end
                  end else if (hit) begin
                     n.st_next = r.shreg[0] ? st_tx : st_rx;
                  end
                  // only the first address byte carries the r/w bit
                  if (r.st == st_addr_hi) begin
                     n.rw = r.shreg[0];
                  end

                  if (n.st_next == st_idle) begin
                     // silent drop on a mismatch
                     n.st = st_idle;
                  end else begin
                     if (full) begin
                        n.ov = 1'b1;
                     end else begin
                        n.data_buffer = r.shreg;
                        n.bf          = 1'b1;
                     end
                     n.ack_hw = !full;
                     if (hold_en) begin
                        n.ack_ok   = !full && !ack_data_value;
                        n.ack_time = 1'b1;
                        n.int_flag = 1'b1;
                        n.scl_hold = 1'b1;
                     end else begin
                        n.ack_ok = !full;
                     end
                     n.sda_drive = n.ack_ok;
                  end
               end
            end else if (r.bits == `BITS_ACK) begin
               n.bits      = `BITS_ZERO;
               n.sda_drive = 1'b0;
               n.ack_time  = 1'b0;
               if (r.st == st_tx) begin
                  n.int_flag = 1'b1;
                  n.tx_need  = 1'b1;
                  n.scl_hold = 1'b1;
               end else if (!r.ack_ok) begin
                  n.st = st_idle;
               end else begin
                  n.st       = r.st_next;
                  n.int_flag = 1'b1;
                  if (r.st_next == st_tx || r.st_next == st_addr_lo) begin
                     // stretch until data or new address is ready
                     n.tx_need  = (r.st_next == st_tx);
                     n.scl_hold = 1'b1;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         r             <= '0;
         r.st          <= st_idle;
         r.st_next     <= st_idle;
         r.scl_q       <= 1'b1;
         r.sda_q       <= 1'b1;
         r.ack_status  <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // open-drain pins drive low only
   assign scl_out               = 1'b0;
   assign sda_out               = 1'b0;
   assign scl_oe_n              = !r.scl_hold;
   assign sda_oe_n              = !r.sda_drive;
   assign data_buffer           = r.data_buffer;
   assign buffer_full_flag      = r.bf;
   assign receive_overflow_flag = r.ov;
   assign serial_int_flag       = r.int_flag;
   assign ack_status_bit        = r.ack_status;
   assign ack_time_flag         = r.ack_time;
   assign start_seen            = r.start_seen;
   assign stop_seen             = r.stop_seen;
   assign bus_collision         = r.collision;
   assign read_mode             = r.rw;
   assign prior_match           = r.prior_match;
   assign bus_active            = r.bus_active;
endmodule : i2c_slave

// ===== i2c_slave_bench.sv
// self-checking bench for the two-wire slave
`include "i2c_slave_defines.svh"
module i2c_slave_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       mclk, reset;
   wire        m_scl, m_sda, scl_w, sda_w, scl_oe_n, sda_oe_n;
   logic [3:0] port_mode_field;
   logic [7:0] own_address, address_mask, tx_data;
   logic       address_hold_enable, data_hold_enable, ack_data_value;
   logic       start_int_enable, stop_int_enable, buffer_read, int_clear;
   logic       overflow_clear, collision_clear;
   logic       release_clock = 1'b0;
   logic       tx_load = 1'b0;
   wire  [7:0] data_buffer;
   wire        buffer_full_flag, receive_overflow_flag, serial_int_flag;
   wire        ack_status_bit, ack_time_flag, start_seen, stop_seen;
   wire        bus_collision, read_mode, prior_match, bus_active;
   logic [7:0] q[$];
   logic       bf_q = 1'b0;
   logic       at_seen = 1'b0;
   int         held = 0;
   int         mismatches = 0;
   int         n_tests = 0;
   assign scl_w = m_scl & scl_oe_n;
   assign sda_w = m_sda & sda_oe_n;
   i2c_master_model u_mst (.mclk(mclk), .scl(scl_w), .sda(sda_w),
      .m_scl(m_scl), .m_sda(m_sda));
   i2c_slave u_dut (.mclk(mclk), .reset(reset), .scl_in(scl_w),
      .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(),
      .sda_oe_n(sda_oe_n), .port_mode_field(port_mode_field),
      .own_address(own_address), .address_mask(address_mask),
      .address_hold_enable(address_hold_enable),
      .data_hold_enable(data_hold_enable),
      .ack_data_value(ack_data_value),
      .start_int_enable(start_int_enable),
      .stop_int_enable(stop_int_enable), .buffer_read(buffer_read),
      .int_clear(int_clear), .overflow_clear(overflow_clear),
      .collision_clear(collision_clear), .release_clock(release_clock),
      .tx_load(tx_load), .tx_data(tx_data), .data_buffer(data_buffer),
      .buffer_full_flag(buffer_full_flag),
      .receive_overflow_flag(receive_overflow_flag),
      .serial_int_flag(serial_int_flag), .ack_status_bit(ack_status_bit),
      .ack_time_flag(ack_time_flag), .start_seen(start_seen),
      .stop_seen(stop_seen), .bus_collision(bus_collision),
      .read_mode(read_mode), .prior_match(prior_match),
      .bus_active(bus_active));
   task automatic chk(input string nm, input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic conclude;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic sw;
      @(negedge mclk);
      {buffer_read, int_clear, overflow_clear, collision_clear} = 4'hf;
      @(negedge mclk);
      {buffer_read, int_clear, overflow_clear, collision_clear} = 4'h0;
   endtask : sw
   task automatic wr(input logic [7:0] b, input logic e, input logic p);
      logic a;
      if (p) q.push_back(b);
      u_mst.wbyte(b, a);
      chk("ack", e, a);
   endtask : wr
   // software stand-in: frees any stretch after 40 cycles
   always @(negedge mclk) begin
      held <= (scl_oe_n === 1'b0) ? held + 1 : 0;
      release_clock <= (held == 40);
      tx_load <= (held == 40) && (read_mode === 1'b1);
      at_seen <= at_seen | (ack_time_flag === 1'b1);
   end
   always @(negedge mclk) begin
      bf_q <= buffer_full_flag;
      if (buffer_full_flag === 1'b1 && bf_q === 1'b0)
         chk("buf", q.size() > 0 ? q.pop_front() : 8'hxx, data_buffer);
   end
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      repeat (40000) @(posedge mclk);
      mismatches++;
      conclude();
   end
   initial begin
      logic [7:0] oa, d, t, hi;
      {port_mode_field, own_address, address_mask, tx_data} = '0;
      {address_hold_enable, data_hold_enable, ack_data_value} = '0;
      {start_int_enable, stop_int_enable, buffer_read, int_clear} = '0;
      {overflow_clear, collision_clear} = '0;
      reset = 1'b1;
      void'($urandom(76));
      oa = $urandom | 8'h01;
      d = $urandom;
      t = $urandom;
      repeat (6) @(negedge mclk);
      reset = 1'b0;
      repeat (8) @(negedge mclk);
      {port_mode_field, own_address, address_mask} = {`MODE_7BIT, oa, 8'hff};
      u_mst.start();
      wr({oa[7:1], 1'b0}, 1'b0, 1'b1);
      sw();
      wr(d, 1'b0, 1'b1);
      chk("int", 8'h01, serial_int_flag);
      wr(~d, 1'b1, 1'b0);
      chk("ovf", 8'h01, receive_overflow_flag);
      chk("keep", d, data_buffer);
      u_mst.stop();
      chk("stop", 8'h01, {bus_active, stop_seen});
      chk("atim", 8'h00, at_seen);
      sw();
      start_int_enable = 1'b1;
      u_mst.start();
      chk("sint", 8'h01, serial_int_flag);
      sw();
      wr({oa[7:1] ^ 7'h40, 1'b0}, 1'b1, 1'b0);
      chk("flags", 8'h00, {serial_int_flag, buffer_full_flag});
      {start_int_enable, stop_int_enable} = 2'h1;
      u_mst.stop();
      chk("pint", 8'h01, serial_int_flag);
      sw();
      {port_mode_field, address_mask} = {`MODE_7BIT_SP, 8'h7f};
      {stop_int_enable, address_hold_enable, data_hold_enable} = 3'h3;
      u_mst.start();
      chk("spint", 8'h01, serial_int_flag);
      sw();
      wr({~oa[7], oa[6:1], 1'b0}, 1'b0, 1'b1);
      sw();
      ack_data_value = 1'b1;
      wr(t, 1'b1, 1'b1);
      chk("atim", 8'h01, at_seen);
      u_mst.stop();
      sw();
      {port_mode_field, address_mask} = {`MODE_7BIT, 8'hff};
      {address_hold_enable, data_hold_enable, ack_data_value} = 3'h0;
      tx_data = d;
      u_mst.start();
      wr({oa[7:1], 1'b1}, 1'b0, 1'b1);
      chk("rw", 8'h01, read_mode);
      sw();
      u_mst.rbyte(hi, 1'b0);
      chk("rd0", d, hi);
      chk("ackst", 8'h00, ack_status_bit);
      tx_data = t;
      u_mst.rbyte(hi, 1'b1);
      chk("rd1", t, hi);
      chk("ackst", 8'h01, ack_status_bit);
      u_mst.stop();
      sw();
      u_mst.start();
      wr({oa[7:1], 1'b1}, 1'b0, 1'b1);
      sw();
      tx_data = 8'hff;
      u_mst.wbyte(8'h00, hi[0]);
      chk("coll", 8'h01, bus_collision);
      u_mst.stop();
      sw();
      port_mode_field = `MODE_10BIT;
      own_address = {5'h00, oa[2:1], 1'b0};
      hi = {`TENBIT_HI_TAG, oa[2:1], 1'b0};
      u_mst.start();
      wr(hi, 1'b0, 1'b1);
      sw();
      own_address = oa;
      wr(oa, 1'b0, 1'b1);
      chk("prior", 8'h01, prior_match);
      sw();
      tx_data = d;
      u_mst.start();
      wr(hi | 8'h01, 1'b0, 1'b1);
      u_mst.rbyte(t, 1'b1);
      chk("rd10", d, t);
      u_mst.stop();
      chk("prior", 8'h00, prior_match);
      sw();
      conclude();
   end
endmodule : i2c_slave_bench

// ===== i2c_slave_checker.sv
// port assertions for the two-wire slave
module i2c_slave_checker (
   // clock and reset
   input wire logic       mclk,
   input wire logic       reset,
   // pins and configuration
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       scl_oe_n,
   input wire logic       sda_oe_n,
   input wire logic [3:0] port_mode_field,
   input wire logic       address_hold_enable,
   input wire logic       data_hold_enable,
   // status
   input wire logic       buffer_full_flag,
   input wire logic       receive_overflow_flag,
   input wire logic       serial_int_flag,
   input wire logic       ack_time_flag,
   input wire logic       start_seen,
   input wire logic       stop_seen,
   input wire logic       read_mode,
   input wire logic       prior_match,
   input wire logic       bus_active
);
   logic on;
   logic sp;
   logic hold;
   assign on   = (port_mode_field[2:1] == 2'h3);
   assign sp   = on & port_mode_field[3];
   assign hold = address_hold_enable | data_hold_enable;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // raw pins: the core sees edges a few cycles late
   AST_START_DET: assert property (
      $fell(sda_in) && scl_in && $past(scl_in)
      |-> ##[1:8] start_seen && bus_active)
      else $error("start missed");
   AST_STOP_DET: assert property (
      $rose(sda_in) && scl_in && $past(scl_in) && bus_active
      |-> ##[1:8] stop_seen && !bus_active)
      else $error("stop missed");
   AST_SP_INT: assert property (
      sp && $fell(sda_in) && scl_in && $past(scl_in)
      |-> ##[1:8] serial_int_flag)
      else $error("no condition interrupt");
   AST_DRIVE_LOW: assert property (
      $fell(sda_oe_n) |-> !scl_in)
      else $error("sda driven while scl high");
   AST_HW_ACK: assert property (
      $rose(buffer_full_flag) && !hold && !receive_overflow_flag
      && !read_mode |-> ##[0:2] !sda_oe_n)
      else $error("no hardware ack");
   AST_OV_NACK: assert property (
      $rose(receive_overflow_flag) |-> sda_oe_n [*8])
      else $error("ack despite overflow");
   AST_ACK_TIME_FLAG: assert property (
      $rose(ack_time_flag) |-> hold)
      else $error("ack time without hold");
   AST_PRIOR_CLR: assert property (
      $fell(bus_active) |-> ##[0:2] !prior_match)
      else $error("prior match kept");
   AST_MODE_OFF: assert property (
      !on && !$past(on) |-> sda_oe_n && scl_oe_n)
      else $error("drive while off");
   cover property (sp && start_seen);
   cover property ($rose(prior_match));
   cover property ($rose(receive_overflow_flag));
endmodule : i2c_slave_checker

bind i2c_slave i2c_slave_checker u_chk (.mclk(mclk), .reset(reset),
   .scl_in(scl_in), .sda_in(sda_in), .scl_oe_n(scl_oe_n),
   .sda_oe_n(sda_oe_n), .port_mode_field(port_mode_field),
   .address_hold_enable(address_hold_enable),
   .data_hold_enable(data_hold_enable),
   .buffer_full_flag(buffer_full_flag),
   .receive_overflow_flag(receive_overflow_flag),
   .serial_int_flag(serial_int_flag), .ack_time_flag(ack_time_flag),
   .start_seen(start_seen), .stop_seen(stop_seen),
   .read_mode(read_mode), .prior_match(prior_match),
   .bus_active(bus_active));

// ===== i2c_slave_defines.svh
// constants for the two-wire slave port
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH
`define MODE_7BIT       4'h6
`define MODE_10BIT      4'h7
`define MODE_7BIT_SP    4'he
`define MODE_10BIT_SP   4'hf
`define TENBIT_HI_TAG   5'h1e
`define BITS_DATA       4'h8
`define BITS_ACK        4'h9
`define BITS_ZERO       4'h0
`define BYTE_ZERO       8'h00
`define BYTE_ONE        8'h01
`endif

// ===== i2c_slave_pkg.sv
// types shared by the two-wire slave port
package i2c_slave_pkg;
   typedef enum logic [2:0] {
      st_idle,
      st_addr_hi,
      st_addr_lo,
      st_rx,
      st_tx
   } state_t;

   typedef struct packed {
      state_t     st;
      state_t     st_next;
      logic [3:0] bits;
      logic [7:0] shreg;
      logic [7:0] tx_buf;
      logic       tx_ready;
      logic       tx_need;
      logic       scl_q;
      logic       sda_q;
      logic       low_seen;
      logic       rw;
      logic       prior_match;
      logic       sda_drive;
      logic       scl_hold;
      logic       ack_hw;
      logic       ack_ok;
      logic [7:0] data_buffer;
      logic       bf;
      logic       ov;
      logic       int_flag;
      logic       ack_status;
      logic       ack_time;
      logic       start_seen;
      logic       stop_seen;
      logic       collision;
      logic       bus_active;
   } core_t;
endpackage : i2c_slave_pkg

// ===== line_sync.sv
// three-stage synchroniser with agreement filter for one bus line
module line_sync (
   // clock and reset
   input  wire logic mclk,
   input  wire logic reset,
   // line
   input  wire logic line_in,
   output logic      line_level
);
   logic [2:0] ff_r;
   logic       level_r;

   // first stage is read only by the second
   always_ff @(posedge mclk) begin
      if (reset) begin
         ff_r    <= 3'h7;
         level_r <= 1'b1;
      end else begin
         ff_r <= {ff_r[1:0], line_in};
         if (ff_r[1] == ff_r[2]) begin
            level_r <= ff_r[2];
         end
      end
   end

   assign line_level = level_r;
endmodule : line_sync
